// *** design/pdef_mux.sv ***
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`include "pdef_map.svh"
// Contract
// - Port D upper bits enable Schmitt inputs
// - Port E upper bits enable Schmitt inputs
// - Port F bits 19:16 enable Schmitt inputs
// - PD15: GPIO, serial transmit, second CAN transmit
// - PD14: GPIO, serial receive, second CAN receive
// - PD13..8 select fourth SPI unit pins
// - PD7/PD6 select first CAN transmit/receive
// - PD5..0 select third SPI unit pins
// - PE5: GPIO, PWM_CHANNEL_FIVE, timer external, timer
// - PE1/PE0 select PWM seven and six
// - PF3/PF2 select PS/2 clock and data
// - PF1/PF0 select crystal input and output
// - PF1/PF0 read-only, from configuration bit
// - PF3/PF2 reset to one
// - Port D and E words reset zero
module pdef_mux
  import pdef_pkg::*;
(
  // Clock, reset and enable
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 clk_en,
  // Nonvolatile crystal pin configuration bit
  input  wire logic                 crystal_pin_config_bit,
  // AXI4-Lite write address
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [11:0]          s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  // AXI4-Lite write response
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [11:0]          s_axi_araddr,
  // AXI4-Lite read data
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  // Schmitt-trigger enables
  output logic [15:0]               port_d_schmitt_enable,
  output logic [15:0]               port_e_schmitt_enable,
  output logic [3:0]                port_f_schmitt_enable,
  // Pin functions
  output pdef_pkg::pdef_d1415_fn_t  port_d_pin15_fn,
  output pdef_pkg::pdef_d1415_fn_t  port_d_pin14_fn,
  output logic [13:0]               port_d_periph_sel,
  output pdef_pkg::pdef_e5_fn_t     port_e_pin5_fn,
  output logic [1:0]                port_e_pwm_sel,
  output logic [3:0]                port_f_periph_sel
);
  import pdef_pkg::*;

  // ****************************************
  // Register state
  // ****************************************
  logic [31:0] port_d_q;
  logic [31:0] port_e_q;
  logic [3:0]  port_f_type_q;
  logic [1:0]  port_f_ps2_q;
  logic [1:0]  port_f_xtal_q;
  logic [2:0]  alt_q;
  logic        cfg_meta_q;
  logic        cfg_sync_q;

  // ****************************************
  // Write channel
  // ****************************************
  logic        aw_held_q;
  logic [11:0] aw_addr_q;
  logic        w_held_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        do_write;
  logic        wr_hit;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] s, input logic [31:0] wmask);
    logic [31:0] m;
    m = strb_mask(s) & wmask;
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `PDEF_OFS_PORT_D) || (a == `PDEF_OFS_PORT_E) ||
             (a == `PDEF_OFS_PORT_F) || (a == `PDEF_OFS_ALT);
  endfunction

  // Address and data are latched independently so either may arrive first
  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_hit   = mapped(aw_addr_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q     <= 1'b0;
      aw_addr_q     <= 12'h000;
      s_axi_awready <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held_q && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q     <= 1'b1;
        aw_addr_q     <= {s_axi_awaddr[11:2], 2'h0};
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q     <= 1'b0;
      w_data_q     <= 32'h00000000;
      w_strb_q     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (clk_en) begin
      s_axi_wready <= !w_held_q && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q     <= 1'b1;
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PDEF_RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PDEF_RESP_OKAY : `PDEF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_d_q <= `PDEF_D_RESET;
      port_e_q <= `PDEF_E_RESET;
      alt_q    <= 3'h0;
    end else if (clk_en && do_write) begin
      if (aw_addr_q == `PDEF_OFS_PORT_D) begin
        port_d_q <= merge(port_d_q, w_data_q, w_strb_q, `PDEF_D_MASK);
      end
      if (aw_addr_q == `PDEF_OFS_PORT_E) begin
        port_e_q <= merge(port_e_q, w_data_q, w_strb_q, `PDEF_E_MASK);
      end
      if (aw_addr_q == `PDEF_OFS_ALT) begin
        alt_q <= 3'(merge(32'(alt_q), w_data_q, w_strb_q, `PDEF_ALT_MASK));
      end
    end
  end

  // Crystal select bits are never written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_f_type_q <= 4'h0;
      port_f_ps2_q  <= `PDEF_F_PS2_RESET;
    end else if (clk_en && do_write && aw_addr_q == `PDEF_OFS_PORT_F) begin
      port_f_type_q <= w_strb_q[2] ? w_data_q[`PDEF_TYPE_LSB +: `PDEF_F_PINS] : port_f_type_q;
      port_f_ps2_q  <= w_strb_q[0] ? w_data_q[3:2] : port_f_ps2_q;
    end
  end

  // Configuration bit comes from outside the bus domain, so it is synchronised
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Synchroniser keeps running in reset so the crystal bits reset to the configured value
      cfg_meta_q    <= crystal_pin_config_bit;
      cfg_sync_q    <= cfg_meta_q;
      port_f_xtal_q <= {2{cfg_sync_q}};
    end else if (clk_en) begin
      cfg_meta_q    <= crystal_pin_config_bit;
      cfg_sync_q    <= cfg_meta_q;
      port_f_xtal_q <= {2{cfg_sync_q}};
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic [31:0] port_f_word;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign port_f_word = {12'h000, port_f_type_q, 12'h000, port_f_ps2_q, port_f_xtal_q};

  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    case ({s_axi_araddr[11:2], 2'h0})
      `PDEF_OFS_PORT_D: rd_word = port_d_q;
      `PDEF_OFS_PORT_E: rd_word = port_e_q & `PDEF_E_MASK;
      `PDEF_OFS_PORT_F: rd_word = port_f_word;
      `PDEF_OFS_ALT:    rd_word = {29'h0, alt_q};
      default:          rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `PDEF_RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? `PDEF_RESP_OKAY : `PDEF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Function decode and registered outputs
  // ****************************************
  pdef_d1415_fn_t pd15_c;
  pdef_d1415_fn_t pd14_c;
  pdef_e5_fn_t    pe5_c;
  logic [15:0]    d_sel_c;
  logic [1:0]     e_sel_c;
  logic [3:0]     f_sel_c;

  pdef_decode u_decode (
    .port_d_word (port_d_q),
    .port_e_word (port_e_q),
    .port_f_word (port_f_word),
    .alt_word    (alt_q),
    .pd15_fn     (pd15_c),
    .pd14_fn     (pd14_c),
    .pe5_fn      (pe5_c),
    .d_sel       (d_sel_c),
    .e_pwm_sel   (e_sel_c),
    .f_sel       (f_sel_c)
  );

  // One cycle after the register update; reset values follow reset words
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_d_schmitt_enable <= 16'h0000;
      port_e_schmitt_enable <= 16'h0000;
      port_f_schmitt_enable <= 4'h0;
      port_d_pin15_fn       <= PDEF_D1415_GPIO;
      port_d_pin14_fn       <= PDEF_D1415_GPIO;
      port_d_periph_sel     <= 14'h0000;
      port_e_pin5_fn        <= PDEF_E5_GPIO;
      port_e_pwm_sel        <= 2'h0;
      port_f_periph_sel     <= {`PDEF_F_PS2_RESET, port_f_xtal_q};
    end else if (clk_en) begin
      port_d_schmitt_enable <= port_d_q[`PDEF_TYPE_LSB +: `PDEF_SEL_W];
      port_e_schmitt_enable <= port_e_q[`PDEF_TYPE_LSB +: `PDEF_SEL_W];
      port_f_schmitt_enable <= port_f_type_q;
      port_d_pin15_fn       <= pd15_c;
      port_d_pin14_fn       <= pd14_c;
      port_d_periph_sel     <= d_sel_c[13:0];
      port_e_pin5_fn        <= pe5_c;
      port_e_pwm_sel        <= e_sel_c;
      port_f_periph_sel     <= f_sel_c;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_schmitt_d;
    @(posedge aclk) disable iff (!aresetn)
      clk_en |=> port_d_schmitt_enable == $past(port_d_q[31:16]);
  endproperty
  a_schmitt_d: assert property (p_schmitt_d) else $error("port d schmitt mismatch");

  property p_schmitt_e;
    @(posedge aclk) disable iff (!aresetn)
      clk_en |=> port_e_schmitt_enable == $past(port_e_q[31:16]);
  endproperty
  a_schmitt_e: assert property (p_schmitt_e) else $error("port e schmitt mismatch");

  property p_schmitt_f;
    @(posedge aclk) disable iff (!aresetn)
      clk_en |=> port_f_schmitt_enable == $past(port_f_type_q);
  endproperty
  a_schmitt_f: assert property (p_schmitt_f) else $error("port f schmitt mismatch");

  property p_pd15;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && port_d_q[15] && alt_q[0]) |=> port_d_pin15_fn == PDEF_D1415_CAN;
  endproperty
  a_pd15: assert property (p_pd15) else $error("pd15 not on second can");

  property p_pd14;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && !port_d_q[14]) |=> port_d_pin14_fn == PDEF_D1415_GPIO;
  endproperty
  a_pd14: assert property (p_pd14) else $error("pd14 not gpio");

  property p_pe5;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && port_e_q[5] && alt_q == 3'h4) |=> port_e_pin5_fn == PDEF_E5_TMR_EXT;
  endproperty
  a_pe5: assert property (p_pe5) else $error("pe5 timer ext not chosen");

  property p_xtal_ro;
    @(posedge aclk) disable iff (!aresetn)
      (clk_en && cfg_sync_q) |=> port_f_xtal_q == 2'h3;
  endproperty
  a_xtal_ro: assert property (p_xtal_ro) else $error("crystal bits not from config");

  property p_f_reset;
    @(posedge aclk) !aresetn |=> port_f_ps2_q == 2'h3 && port_d_q == 32'h0 && port_e_q == 32'h0;
  endproperty
  a_f_reset: assert property (p_f_reset) else $error("reset values wrong");

  property p_e_resv;
    @(posedge aclk) disable iff (!aresetn)
      (port_e_q & ~`PDEF_E_MASK) == 32'h0;
  endproperty
  a_e_resv: assert property (p_e_resv) else $error("port e reserved bits set");

  property p_sel_d;
    @(posedge aclk) disable iff (!aresetn)
      clk_en |=> port_d_periph_sel == $past(port_d_q[13:0]);
  endproperty
  a_sel_d: assert property (p_sel_d) else $error("port d select mismatch");

  property p_sel_ef;
    @(posedge aclk) disable iff (!aresetn)
      clk_en |=> port_e_pwm_sel == $past(port_e_q[1:0]) && port_f_periph_sel[3:2] == $past(port_f_ps2_q);
  endproperty
  a_sel_ef: assert property (p_sel_ef) else $error("port e/f select mismatch");
endmodule

// *** design/pdef_map.svh ***
`ifndef PDEF_MAP_SVH
`define PDEF_MAP_SVH
// Register byte offsets
`define PDEF_OFS_PORT_D      12'h03C
`define PDEF_OFS_PORT_E      12'h040
`define PDEF_OFS_PORT_F      12'h044
`define PDEF_OFS_ALT         12'h048
// Field layout
`define PDEF_TYPE_LSB        16
`define PDEF_SEL_W           16
`define PDEF_F_PINS          4
// Writable masks and reset values
`define PDEF_D_MASK          32'hFFFFFFFF
`define PDEF_E_MASK          32'hFFFF0023
`define PDEF_F_WMASK         32'h000F000C
`define PDEF_D_RESET         32'h00000000
`define PDEF_E_RESET         32'h00000000
`define PDEF_F_RESET         32'h0000000C
`define PDEF_F_PS2_RESET     2'h3
`define PDEF_ALT_MASK        32'h00000007
`define PDEF_ALT_RESET       32'h00000000
// Alternate select bit positions
`define PDEF_ALT_CAN2        0
`define PDEF_ALT_TM1         1
`define PDEF_ALT_T1EX        2
// Port E pin select positions
`define PDEF_E_PIN5          5
`define PDEF_E_PIN1          1
`define PDEF_E_PIN0          0
// AXI responses
`define PDEF_RESP_OKAY       2'h0
`define PDEF_RESP_SLVERR     2'h2
`endif

// *** design/pdef_pkg.sv ***
package pdef_pkg;
  // Function routed to port E pin 5
  typedef enum logic [1:0] {
    PDEF_E5_GPIO,
    PDEF_E5_PWM,
    PDEF_E5_TMR_EXT,
    PDEF_E5_TMR
  } pdef_e5_fn_t;
  // Function routed to port D pins 15 and 14
  typedef enum logic [1:0] {
    PDEF_D1415_GPIO,
    PDEF_D1415_UART,
    PDEF_D1415_CAN
  } pdef_d1415_fn_t;
endpackage

// *** design/pdef_decode.sv ***
`timescale 1ns/10ps
`include "pdef_map.svh"
// ****************************************
// Pin function decode from the control words
// ****************************************
module pdef_decode
  import pdef_pkg::*;
(
  // Control words
  input  wire logic [31:0]    port_d_word,
  input  wire logic [31:0]    port_e_word,
  input  wire logic [31:0]    port_f_word,
  input  wire logic [2:0]     alt_word,
  // Decoded functions
  output pdef_pkg::pdef_d1415_fn_t pd15_fn,
  output pdef_pkg::pdef_d1415_fn_t pd14_fn,
  output pdef_pkg::pdef_e5_fn_t    pe5_fn,
  output logic [15:0]         d_sel,
  output logic [1:0]          e_pwm_sel,
  output logic [3:0]          f_sel
);
  import pdef_pkg::*;

  // Two-bit alt/select pair; the unlisted 10 combination stays on GPIO
  function automatic pdef_d1415_fn_t pair_fn(input logic alt, input logic sel);
    pdef_d1415_fn_t f;
    f = PDEF_D1415_GPIO;
    if (sel && !alt) begin
      f = PDEF_D1415_UART;
    end else if (sel && alt) begin
      f = PDEF_D1415_CAN;
    end
    return f;
  endfunction

  always_comb begin
    pd15_fn = pair_fn(alt_word[`PDEF_ALT_CAN2], port_d_word[15]);
    pd14_fn = pair_fn(alt_word[`PDEF_ALT_CAN2], port_d_word[14]);
  end

  always_comb begin
    case ({alt_word[`PDEF_ALT_T1EX], alt_word[`PDEF_ALT_TM1], port_e_word[`PDEF_E_PIN5]})
      3'h1:    pe5_fn = PDEF_E5_PWM;
      3'h5:    pe5_fn = PDEF_E5_TMR_EXT;
      3'h3:    pe5_fn = PDEF_E5_TMR;
      default: pe5_fn = PDEF_E5_GPIO;
    endcase
  end

  // Pins 15/14 are handled above, so their plain bits are masked off here
  assign d_sel     = {2'h0, port_d_word[13:0]};
  assign e_pwm_sel = {port_e_word[`PDEF_E_PIN1], port_e_word[`PDEF_E_PIN0]};
  assign f_sel     = port_f_word[`PDEF_F_PINS-1:0];
endmodule

// *** tb/pdef_mux_bench.sv ***
`timescale 1ns/10ps
`include "pdef_map.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module pdef_mux_bench;
  import pdef_pkg::*;
  // Generous ceiling: the whole run needs well under two thousand cycles
  localparam int LIMIT = 20000;
  // ****************************************
  // Signals
  // ****************************************
  logic                     aclk, aresetn, clk_en, cfg_bit;
  logic                     s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                     s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                     s_axi_rvalid, s_axi_rready;
  logic [11:0]              s_axi_awaddr, s_axi_araddr;
  logic [31:0]              s_axi_wdata, s_axi_rdata;
  logic [3:0]               s_axi_wstrb, port_f_schmitt_enable, port_f_periph_sel;
  logic [1:0]               s_axi_bresp, s_axi_rresp, port_e_pwm_sel;
  logic [15:0]              port_d_schmitt_enable, port_e_schmitt_enable;
  logic [13:0]              port_d_periph_sel;
  pdef_d1415_fn_t           port_d_pin15_fn, port_d_pin14_fn;
  pdef_e5_fn_t              port_e_pin5_fn;
  logic [31:0]              md, me, mf, ma, rd, rnd;
  logic [1:0]               resp;
  logic [11:0]              addr_tab [0:3];
  int                       seed, bad_count, tests_run, cyc, i;

  pdef_mux i_pdef_mux (
    .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .crystal_pin_config_bit(cfg_bit),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .port_d_schmitt_enable(port_d_schmitt_enable), .port_e_schmitt_enable(port_e_schmitt_enable),
    .port_f_schmitt_enable(port_f_schmitt_enable), .port_d_pin15_fn(port_d_pin15_fn),
    .port_d_pin14_fn(port_d_pin14_fn), .port_d_periph_sel(port_d_periph_sel),
    .port_e_pin5_fn(port_e_pin5_fn), .port_e_pwm_sel(port_e_pwm_sel),
    .port_f_periph_sel(port_f_periph_sel)
  );

  always #2 aclk = ~aclk;

  always @(posedge aclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      bad_count++;
      $display("[FAIL] run did not finish within %0d cycles", LIMIT);
      summarize();
    end
  end

  // ****************************************
  // Expectation functions
  // ****************************************
  function automatic logic [1:0] can_fn(input logic alt, input logic sel);
    return !sel ? 2'h0 : (alt ? 2'h2 : 2'h1);
  endfunction

  function automatic logic [1:0] e5_fn(input logic ext, input logic tmr, input logic sel);
    case ({ext, tmr, sel})
      3'b001:  return 2'h1;
      3'b101:  return 2'h2;
      3'b011:  return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  function automatic logic [31:0] wmask(input logic [11:0] a);
    case (a)
      `PDEF_OFS_PORT_D: return `PDEF_D_MASK;
      `PDEF_OFS_PORT_E: return `PDEF_E_MASK;
      `PDEF_OFS_PORT_F: return `PDEF_F_WMASK;
      `PDEF_OFS_ALT:    return `PDEF_ALT_MASK;
      default:          return 32'h00000000;
    endcase
  endfunction

  function automatic logic [31:0] exp_read(input logic [11:0] a);
    case (a)
      `PDEF_OFS_PORT_D: return md;
      `PDEF_OFS_PORT_E: return me;
      `PDEF_OFS_PORT_F: return mf | {30'h0, cfg_bit, cfg_bit};
      default:          return ma;
    endcase
  endfunction

  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Write through the bus and mirror the masked result in the model
  task automatic wr_m(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & wmask(a);
    axi_wr(a, d, s, resp);
    `CHK("write resp", `PDEF_RESP_OKAY, resp)
    case (a)
      `PDEF_OFS_PORT_D: md = (md & ~bm) | (d & bm);
      `PDEF_OFS_PORT_E: me = (me & ~bm) | (d & bm);
      `PDEF_OFS_PORT_F: mf = (mf & ~bm) | (d & bm);
      default:          ma = (ma & ~bm) | (d & bm);
    endcase
  endtask

  task automatic reg_check(input logic [11:0] a);
    axi_rd(a, rd, resp);
    `CHK("read resp", `PDEF_RESP_OKAY, resp)
    `CHK("read data", exp_read(a), rd)
  endtask

  task automatic reset_model();
    md = `PDEF_D_RESET;
    me = `PDEF_E_RESET;
    mf = `PDEF_F_RESET;
    ma = `PDEF_ALT_RESET;
  endtask

  task automatic chk_out();
    repeat (3) @(posedge aclk);
    `CHK("d schmitt", md[31:16], port_d_schmitt_enable)
    `CHK("e schmitt", me[31:16], port_e_schmitt_enable)
    `CHK("f schmitt", mf[19:16], port_f_schmitt_enable)
    `CHK("pd15 fn", can_fn(ma[0], md[15]), port_d_pin15_fn)
    `CHK("pd14 fn", can_fn(ma[0], md[14]), port_d_pin14_fn)
    `CHK("pd spi4", md[13:8], port_d_periph_sel[13:8])
    `CHK("pd can0", md[7:6], port_d_periph_sel[7:6])
    `CHK("pd spi3", md[5:0], port_d_periph_sel[5:0])
    `CHK("pe5 fn", e5_fn(ma[2], ma[1], me[5]), port_e_pin5_fn)
    `CHK("pe pwm", me[1:0], port_e_pwm_sel)
    `CHK("pf ps2", mf[3:2], port_f_periph_sel[3:2])
    `CHK("pf xtal", {cfg_bit, cfg_bit}, port_f_periph_sel[1:0])
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    clk_en = 1'b1;
    cfg_bit = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    seed = 15;
    bad_count = 0;
    tests_run = 0;
    cyc = 0;
    addr_tab[0] = `PDEF_OFS_PORT_D;
    addr_tab[1] = `PDEF_OFS_PORT_E;
    addr_tab[2] = `PDEF_OFS_PORT_F;
    addr_tab[3] = `PDEF_OFS_ALT;
    reset_model();
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("reset pf sel", 4'hF, port_f_periph_sel)
    repeat (5) @(posedge aclk);
    for (i = 0; i < 4; i++) begin
      axi_rd(addr_tab[i], rd, resp);
      `CHK("reset value", exp_read(addr_tab[i]), rd)
    end
    chk_out();
    // All ones hit every reserved and read-only bit
    for (i = 0; i < 4; i++) begin
      wr_m(addr_tab[i], 32'hFFFFFFFF, 4'hF);
      reg_check(addr_tab[i]);
    end
    chk_out();
    // Every alternate-select combination with the pin selects off and on
    for (i = 0; i < 16; i++) begin
      wr_m(`PDEF_OFS_ALT, {29'h0, i[2:0]}, 4'hF);
      wr_m(`PDEF_OFS_PORT_D, i[3] ? 32'h0000C000 : 32'h00000000, 4'hF);
      wr_m(`PDEF_OFS_PORT_E, i[3] ? 32'h00000020 : 32'h00000000, 4'hF);
      chk_out();
    end
    // Unmapped places answer with an error and change nothing
    for (i = 0; i < 2; i++) begin
      axi_wr(i[0] ? 12'h04C : 12'h038, 32'hFFFFFFFF, 4'hF, resp);
      `CHK("unmapped write", `PDEF_RESP_SLVERR, resp)
      axi_rd(i[0] ? 12'h04C : 12'h038, rd, resp);
      `CHK("unmapped read", `PDEF_RESP_SLVERR, resp)
    end
    for (i = 0; i < 4; i++) begin
      reg_check(addr_tab[i]);
    end
    chk_out();
    // Random registers, data and byte strobes
    for (i = 0; i < 80; i++) begin
      rnd = $random(seed);
      wr_m(addr_tab[rnd[1:0]], $random(seed), rnd[7:4]);
      reg_check(addr_tab[rnd[1:0]]);
      chk_out();
    end
    // Crystal pins follow the configuration bit, but not while frozen
    @(posedge aclk);
    clk_en <= 1'b0;
    cfg_bit <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK("frozen xtal", 2'b11, port_f_periph_sel[1:0])
    clk_en <= 1'b1;
    repeat (6) @(posedge aclk);
    reg_check(`PDEF_OFS_PORT_F);
    wr_m(`PDEF_OFS_PORT_F, 32'h00000003, 4'h1);
    reg_check(`PDEF_OFS_PORT_F);
    chk_out();
    // Second reset in mid-run
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_model();
    @(posedge aclk);
    `CHK("reset pf sel", 4'hC, port_f_periph_sel)
    repeat (5) @(posedge aclk);
    chk_out();
    for (i = 0; i < 4; i++) begin
      reg_check(addr_tab[i]);
    end
    summarize();
  end
endmodule
